/* inc/dac_ctrl_pkg.sv */
// shared constants and types for the converter control block
package dac_ctrl_pkg;

  // register indices; byte address is four times the index
  localparam int unsigned CONTROL_IDX  = 0;
  localparam int unsigned CODE_IDX     = 1;
  localparam logic [11:0] CONTROL_ADDR = 12'(CONTROL_IDX * 4);
  localparam logic [11:0] CODE_ADDR    = 12'(CODE_IDX * 4);

  // control register fields
  localparam int unsigned ENABLE_BIT   = 0;
  localparam int unsigned PIN_BUF_BIT  = 6;
  localparam int unsigned KEEP_RUN_BIT = 7;
  localparam logic [7:0]  CONTROL_MASK = 8'hc1;

  // reset values
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [7:0]  CODE_RESET    = 8'h00;

  // timing
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned STARTUP_NS     = 1000;
  localparam int unsigned STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MAX_RATE_KSPS  = 350;
  // least spacing between code updates, rounded up
  localparam int unsigned MIN_UPDATE_CYCLES =
    (1000000 + MAX_RATE_KSPS * CLK_PERIOD_NS - 1) / (MAX_RATE_KSPS * CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    stOff,
    stRun,
    stSleep,
    stWake
  } convState_t;

endpackage

/* logic/dac_startup_timer.sv */
// start-up interval counter for the converter after wake-up
`timescale 1ns/1ns
module dac_startup_timer #(
  parameter int unsigned CYCLES = dac_ctrl_pkg::STARTUP_CYCLES
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // control
  input  wire logic start,
  input  wire logic abort,
  output logic      done
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic          busy_q;
  logic          busy_d;

  always_comb begin
    count_d = count_q;
    busy_d  = busy_q;
    done    = 1'b0;
    if (abort) begin
      busy_d = 1'b0;
    end else if (start) begin
      count_d = LOAD;
      busy_d  = 1'b1;
    end else if (busy_q) begin
      if (count_q == '0) begin
        done   = 1'b1;
        busy_d = 1'b0;
      end else begin
        count_d = count_q - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_q <= '0;
      busy_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      busy_q  <= busy_d;
    end
  end

endmodule

/* logic/dac_conversion_control.sv */
// APB register file and sequencing for the 8-bit string converter
//
// What this block does
// - enable bit switches the converter on and off
// - code write while enabled starts a conversion
// - code write while disabled only stores
// - setting enable converts the stored code
// - bit 6 turns pin buffer on
// - internal tap live whenever converter enabled
// - bit 7 keeps converting through standby while the peripheral clock is available
// - standby without bit 7 powers everything down
// - wake re-enables, waits start-up, then converts
// - power-down sleep always disables converter and buffer
// - code register holds 8-bit unsigned value
// - debug halt changes nothing
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module dac_conversion_control #(
  parameter int unsigned ADDR_W         = 12,
  parameter int unsigned STARTUP_CYCLES = dac_ctrl_pkg::STARTUP_CYCLES
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // sleep controller, same clock
  input  wire logic              standbySleep,
  input  wire logic              powerDownSleep,
  input  wire logic              perClkAvail,
  // analog core and pin buffer
  output logic                   coreEnable,
  output logic                   pinBufferOn,
  output logic                   internalTapOn,
  output logic                   loadPulse,
  output logic      [7:0]        loadCode
);

  // register file state
  logic [7:0]  control_q;
  logic [7:0]  control_d;
  logic [7:0]  code_q;
  logic [7:0]  code_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  // sequencing state
  dac_ctrl_pkg::convState_t state_q;
  dac_ctrl_pkg::convState_t state_d;
  logic        loadPulse_q;
  logic        loadPulse_d;
  logic [7:0]  loadCode_q;
  logic [7:0]  loadCode_d;
  logic        coreOn_q;
  logic        coreOn_d;
  logic        pinBuf_q;
  logic        pinBuf_d;
  int unsigned wakeAge_q;
  int unsigned wakeAge_d;

  // decode
  logic        setupPhase;
  logic        accessPhase;
  logic        hitControl;
  logic        hitCode;
  logic        mapped;
  logic        ctrlWrite;
  logic        codeWrite;
  logic        enableNext;
  logic        gateSleep;
  logic        timerStart;
  logic        timerAbort;
  logic        timerDone;

  // zero wait states: every access completes in its first access cycle
  assign pready      = 1'b1;
  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable;

  always_comb begin
    hitControl = 1'b0;
    hitCode    = 1'b0;
    if (paddr == ADDR_W'(dac_ctrl_pkg::CONTROL_ADDR)) begin
      hitControl = 1'b1;
    end else if (paddr == ADDR_W'(dac_ctrl_pkg::CODE_ADDR)) begin
      hitCode = 1'b1;
    end
  end

  assign mapped    = hitControl || hitCode;
  assign pslverr   = accessPhase && !mapped;
  // only the low byte lane carries register bits
  assign ctrlWrite = accessPhase && pwrite && hitControl && pstrb[0];
  assign codeWrite = accessPhase && pwrite && hitCode && pstrb[0];

  // register writes; reserved control bits stay zero
  always_comb begin
    control_d = control_q;
    code_d    = code_q;
    if (ctrlWrite) begin
      control_d = pwdata[7:0] & dac_ctrl_pkg::CONTROL_MASK;
    end
    if (codeWrite) begin
      code_d = pwdata[7:0];
    end
  end

  // read data captured in the setup cycle so it is a flop in the access cycle
  always_comb begin
    prdata_d = prdata_q;
    if (setupPhase) begin
      prdata_d = 32'h0000_0000;
      if (hitControl) begin
        prdata_d = {24'h00_0000, control_q};
      end else if (hitCode) begin
        prdata_d = {24'h00_0000, code_q};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      control_q <= dac_ctrl_pkg::CONTROL_RESET;
      code_q    <= dac_ctrl_pkg::CODE_RESET;
      prdata_q  <= 32'h0000_0000;
    end else begin
      control_q <= control_d;
      code_q    <= code_d;
      prdata_q  <= prdata_d;
    end
  end

  assign prdata = prdata_q;

  // sleep gating uses the stored bits; a standby with the peripheral clock gone
  // is treated as a stop, since nothing here could keep converting anyway
  assign gateSleep = powerDownSleep
                     || (standbySleep && !(control_q[dac_ctrl_pkg::KEEP_RUN_BIT] && perClkAvail));
  assign enableNext = control_d[dac_ctrl_pkg::ENABLE_BIT];

  // no debug-halt input exists: a halted processor leaves this logic untouched

  always_comb begin
    state_d     = state_q;
    loadPulse_d = 1'b0;
    loadCode_d  = loadCode_q;
    timerStart  = 1'b0;
    case (state_q)
      dac_ctrl_pkg::stOff: begin
        if (enableNext) begin
          if (gateSleep) begin
            state_d = dac_ctrl_pkg::stSleep;
          end else begin
            state_d     = dac_ctrl_pkg::stRun;
            loadPulse_d = 1'b1;
            loadCode_d  = code_d;
          end
        end
      end
      dac_ctrl_pkg::stRun: begin
        if (!enableNext) begin
          state_d = dac_ctrl_pkg::stOff;
        end else if (gateSleep) begin
          state_d = dac_ctrl_pkg::stSleep;
        end else if (codeWrite) begin
          loadPulse_d = 1'b1;
          loadCode_d  = code_d;
        end
      end
      dac_ctrl_pkg::stSleep: begin
        if (!enableNext) begin
          state_d = dac_ctrl_pkg::stOff;
        end else if (!gateSleep) begin
          state_d    = dac_ctrl_pkg::stWake;
          timerStart = 1'b1;
        end
      end
      dac_ctrl_pkg::stWake: begin
        if (!enableNext) begin
          state_d = dac_ctrl_pkg::stOff;
        end else if (gateSleep) begin
          state_d = dac_ctrl_pkg::stSleep;
        end else if (timerDone) begin
          // writes made while asleep are picked up here
          state_d     = dac_ctrl_pkg::stRun;
          loadPulse_d = 1'b1;
          loadCode_d  = code_d;
        end
      end
      default: begin
        state_d = dac_ctrl_pkg::stOff;
      end
    endcase
  end

  assign timerAbort = (state_q == dac_ctrl_pkg::stWake) && (state_d != dac_ctrl_pkg::stWake) && !timerDone;

  // cycles spent in start-up, so the wake check follows whatever interval is configured
  always_comb begin
    wakeAge_d = (state_q == dac_ctrl_pkg::stWake) ? wakeAge_q + 32'd1 : 32'd0;
  end

  // powered during start-up so the string settles before the first load
  always_comb begin
    coreOn_d = (state_d == dac_ctrl_pkg::stRun) || (state_d == dac_ctrl_pkg::stWake);
    pinBuf_d = coreOn_d && control_d[dac_ctrl_pkg::PIN_BUF_BIT];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q     <= dac_ctrl_pkg::stOff;
      loadPulse_q <= 1'b0;
      loadCode_q  <= dac_ctrl_pkg::CODE_RESET;
      coreOn_q    <= 1'b0;
      pinBuf_q    <= 1'b0;
      wakeAge_q   <= 32'd0;
    end else begin
      state_q     <= state_d;
      loadPulse_q <= loadPulse_d;
      loadCode_q  <= loadCode_d;
      coreOn_q    <= coreOn_d;
      pinBuf_q    <= pinBuf_d;
      wakeAge_q   <= wakeAge_d;
    end
  end

  dac_startup_timer #(
    .CYCLES (STARTUP_CYCLES)
  ) u_startup (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (timerStart),
    .abort   (timerAbort),
    .done    (timerDone)
  );

  assign coreEnable    = coreOn_q;
  assign pinBufferOn   = pinBuf_q;
  assign internalTapOn = coreOn_q;
  assign loadPulse     = loadPulse_q;
  assign loadCode      = loadCode_q;

  property p_write_loads;
    @(posedge sys_clk) disable iff (rst)
    (state_q == dac_ctrl_pkg::stRun) && codeWrite && !gateSleep
    |=> loadPulse && (loadCode == $past(pwdata[7:0]));
  endproperty
  a_write_loads: assert property (p_write_loads) else $error("code write while running gave no load");

  property p_off_no_load;
    @(posedge sys_clk) disable iff (rst)
    (state_q == dac_ctrl_pkg::stOff) && !ctrlWrite |=> !loadPulse && !coreEnable;
  endproperty
  a_off_no_load: assert property (p_off_no_load) else $error("load while disabled");

  property p_enable_loads;
    @(posedge sys_clk) disable iff (rst)
    (state_q == dac_ctrl_pkg::stOff) && ctrlWrite && pwdata[dac_ctrl_pkg::ENABLE_BIT] && !gateSleep
    |=> loadPulse && coreEnable && (loadCode == $past(code_q));
  endproperty
  a_enable_loads: assert property (p_enable_loads) else $error("enable did not convert stored code");

  property p_buffer_needs_core;
    @(posedge sys_clk) disable iff (rst)
    pinBufferOn |-> coreEnable && control_q[dac_ctrl_pkg::PIN_BUF_BIT];
  endproperty
  a_buffer_needs_core: assert property (p_buffer_needs_core) else $error("pin buffer on without cause");

  property p_tap_follows_enable;
    @(posedge sys_clk) disable iff (rst)
    internalTapOn |-> control_q[dac_ctrl_pkg::ENABLE_BIT];
  endproperty
  a_tap_follows_enable: assert property (p_tap_follows_enable) else $error("tap live while disabled");

  property p_standby_runs;
    @(posedge sys_clk) disable iff (rst)
    (state_q == dac_ctrl_pkg::stRun) && standbySleep && !powerDownSleep && perClkAvail
      && control_q[dac_ctrl_pkg::KEEP_RUN_BIT] && !ctrlWrite
    |=> coreEnable && (state_q == dac_ctrl_pkg::stRun);
  endproperty
  a_standby_runs: assert property (p_standby_runs) else $error("stopped in standby with keep-run");

  property p_sleep_gates;
    @(posedge sys_clk) disable iff (rst)
    gateSleep |=> !coreEnable && !pinBufferOn && !loadPulse;
  endproperty
  a_sleep_gates: assert property (p_sleep_gates) else $error("converter powered in gated sleep");

  property p_wake_waits;
    @(posedge sys_clk) disable iff (rst)
    (state_q == dac_ctrl_pkg::stWake) && (wakeAge_q < STARTUP_CYCLES - 1)
    |-> coreEnable ##1 !loadPulse;
  endproperty
  a_wake_waits: assert property (p_wake_waits) else $error("load before start-up elapsed");

  property p_single_pulse;
    @(posedge sys_clk) disable iff (rst)
    loadPulse |=> !loadPulse;
  endproperty
  a_single_pulse: assert property (p_single_pulse) else $error("load pulse longer than one cycle");

  property p_unmapped_err;
    @(posedge sys_clk) disable iff (rst)
    accessPhase && !mapped |-> pslverr ##1 ($stable(control_q) && $stable(code_q));
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");

endmodule

/* verif/dac_core_model.sv */
// behavioural model of the string converter core and its pin buffer
`timescale 1ns/1ns
module dac_core_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // from the control block
  input  wire logic       coreEnable,
  input  wire logic       pinBufferOn,
  input  wire logic       loadPulse,
  input  wire logic [7:0] loadCode,
  // observation
  output logic      [7:0] heldCode,
  output logic      [7:0] pinLevel,
  output int              loadCount,
  output int              badLoads
);
  // every pulse cycle counts, so a pulse longer than one cycle shows as extra loads
  always @(posedge sys_clk) begin
    if (rst) begin
      heldCode  <= 8'h00;
      loadCount <= 0;
      badLoads  <= 0;
    end else if (loadPulse) begin
      heldCode  <= loadCode;
      loadCount <= loadCount + 1;
      if (!coreEnable) begin
        badLoads <= badLoads + 1;
      end
    end
  end
  // a released pin shows the inverse of the last level, so a stale value cannot pass
  assign pinLevel = pinBufferOn ? heldCode : ~heldCode;
endmodule

/* verif/tb_top.sv */
// self-checking testbench for the converter control block
`timescale 1ns/1ns
module tb_top;
  localparam logic [11:0] CA = dac_ctrl_pkg::CONTROL_ADDR;
  localparam logic [11:0] DA = dac_ctrl_pkg::CODE_ADDR;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb;
  logic        standbySleep, powerDownSleep, perClkAvail, rerr;
  logic        coreEnable, pinBufferOn, internalTapOn, loadPulse;
  logic [7:0]  loadCode, heldCode, pinLevel;
  int          loadCount, badLoads, failures, n_tests, c0;

  // short start-up keeps the wake scenarios brief
  dac_conversion_control #(.ADDR_W(12), .STARTUP_CYCLES(2)) DUT (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .standbySleep(standbySleep), .powerDownSleep(powerDownSleep),
    .perClkAvail(perClkAvail), .coreEnable(coreEnable), .pinBufferOn(pinBufferOn),
    .internalTapOn(internalTapOn), .loadPulse(loadPulse), .loadCode(loadCode));

  dac_core_model core (
    .sys_clk(sys_clk), .rst(rst), .coreEnable(coreEnable), .pinBufferOn(pinBufferOn),
    .loadPulse(loadPulse), .loadCode(loadCode), .heldCode(heldCode), .pinLevel(pinLevel),
    .loadCount(loadCount), .badLoads(badLoads));

  always #50 sys_clk = ~sys_clk;

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; response taken at the edge where pready is seen
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(n, 1);
    #10;
  endtask

  // sleep inputs change at a clock edge, as the sleep controller would
  task automatic sleepIn(input logic [2:0] v);
    @(posedge sys_clk);
    {standbySleep, powerDownSleep, perClkAvail} <= v;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hf);
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'hf);
    chk(rdat, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask

  task automatic outChk(input logic [2:0] e);
    chk({coreEnable, pinBufferOn, internalTapOn}, e);
  endtask

  // bounded wait for the next load; no fixed latency is assumed
  task automatic waitLoad(input int c);
    int n;
    n = 0;
    while (loadCount == c && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    #10;
    chk(loadCount, c + 1);
  endtask

  initial begin
    #500000;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test;
  end

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {standbySleep, powerDownSleep, perClkAvail} = 3'b001;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    idle(1);
    outChk(3'b000);
    rdChk(CA, 32'h0);
    rdChk(DA, 32'h0);
    wr(DA, 32'h5a);
    idle(3);
    chk(loadCount, 0);
    rdChk(DA, 32'h5a);
    wr(CA, 32'h01);
    waitLoad(0);
    chk(heldCode, 8'h5a);
    outChk(3'b101);
    wr(CA, 32'h3f);
    rdChk(CA, 32'h01);
    wr(CA, 32'h41);
    idle(2);
    outChk(3'b111);
    chk(pinLevel, 8'h5a);
    c0 = loadCount;
    wr(DA, 32'ha5);
    idle(2);
    chk(loadCount, c0 + 1);
    chk(heldCode, 8'ha5);
    idle(dac_ctrl_pkg::MIN_UPDATE_CYCLES);
    wr(DA, 32'hff);
    idle(2);
    chk(heldCode, 8'hff);
    xfer(1'b1, DA, 32'h11, 4'h0);
    rdChk(DA, 32'hff);
    xfer(1'b1, 12'h008, 32'h11, 4'hf);
    chk(rerr, 1'b1);
    rdChk(12'h008, 32'h0);
    chk(rerr, 1'b1);
    wr(CA, 32'hc1);
    sleepIn(3'b101);
    idle(3);
    outChk(3'b111);
    idle(dac_ctrl_pkg::MIN_UPDATE_CYCLES);
    wr(DA, 32'h33);
    idle(2);
    chk(heldCode, 8'h33);
    sleepIn(3'b100);
    idle(2);
    outChk(3'b000);
    idle(dac_ctrl_pkg::MIN_UPDATE_CYCLES);
    c0 = loadCount;
    wr(DA, 32'h77);
    idle(3);
    chk(loadCount, c0);
    sleepIn(3'b101);
    idle(2);
    outChk(3'b111);
    chk(loadCount, c0);
    waitLoad(c0);
    chk(heldCode, 8'h77);
    wr(CA, 32'h41);
    idle(2);
    outChk(3'b000);
    c0 = loadCount;
    sleepIn(3'b001);
    waitLoad(c0);
    outChk(3'b111);
    wr(CA, 32'hc1);
    sleepIn(3'b011);
    idle(2);
    outChk(3'b000);
    c0 = loadCount;
    sleepIn(3'b001);
    idle(8);
    chk(loadCount, c0 + 1);
    wr(CA, 32'h40);
    idle(2);
    outChk(3'b000);
    c0 = loadCount;
    wr(DA, 32'h01);
    idle(3);
    chk(loadCount, c0);
    chk(badLoads, 0);
    end_of_test;
  end
endmodule
